// file: shared/sac_pkg.sv
`default_nettype none
package sac_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_DELAY   = 8'h04;
    localparam logic [7:0] OFF_DONE    = 8'h08;
    localparam logic [7:0] OFF_ONESHOT = 8'h0C;
    localparam logic [7:0] OFF_PERIOD  = 8'h10;
    localparam logic [7:0] OFF_RES0    = 8'h14;
    localparam logic [7:0] OFF_CLKCFG  = 8'h7C;
    localparam logic [7:0] OFF_REFSEL  = 8'h80;
    localparam logic [7:0] OFF_REFCTL  = 8'h84;
    localparam logic [7:0] OFF_CORE    = 8'h88;
    // Control register bits
    localparam int CTL_ENABLE   = 0;
    localparam int CTL_ONESHOT  = 1;
    localparam int CTL_PERIODIC = 2;
    localparam int CTL_PSDIS    = 3;
    localparam int CTL_HWRST    = 4;
    localparam int CTL_PDONE    = 6;
    localparam int CTL_ODONE    = 7;
    // Core control fields
    localparam int CORE_WARM_LO = 7;
    localparam int CORE_JUSTIFY = 3;
    localparam int CORE_RES_LO  = 1;
    localparam logic [1:0]  RES_10BIT   = 2'h2;
    localparam logic [1:0]  RES_12BIT   = 2'h3;
    localparam logic [9:0]  WARM_RESET  = 10'h202;
    localparam logic [7:0]  CLK_CNT_RST = 8'h01;
    // Reference control fields
    localparam int REF_STAT_LO  = 30;
    localparam int REF_PADDRV   = 29;
    localparam int REF_SW_LO    = 16;
    // Delay tick: 40 us at 25 MHz
    localparam int CLK_MHZ      = 25;
    localparam int TICK_US      = 40;
    localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;
    typedef enum logic [2:0] {SAC_IDLE, SAC_REFSW, SAC_WARM, SAC_CONV, SAC_NEXT} sac_state_type;
endpackage : sac_pkg
`default_nettype wire

// file: core/sac_clkgen.sv
`timescale 1ns/1ps
`default_nettype none
// Converter clock divider with separate high and low counts
module sac_clkgen (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    input  wire logic       run_i,
    input  wire logic [7:0] high_cnt_i,
    input  wire logic [7:0] low_cnt_i,
    output logic            cclk_o,
    output logic            rise_o
);
    logic [7:0] cnt_reg;

    // (R17) high/low count divider
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt_reg <= 8'h01;
            cclk_o  <= 1'b0;
            rise_o  <= 1'b0;
        end else if (ce_i) begin
            rise_o <= 1'b0;
            if (cnt_reg >= (cclk_o ? high_cnt_i : low_cnt_i)) begin
                cnt_reg <= 8'h01;
                cclk_o  <= !cclk_o;
                rise_o  <= !cclk_o;
            end else begin
                cnt_reg <= cnt_reg + 8'h01;
            end
        end
    end
endmodule : sac_clkgen
`default_nettype wire

// file: core/sac_sequencer.sv
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
// Function
// (R1) Hardware-reset bit holds converter logic in reset, registers kept.
// (R2) Power-saving disable bit 0 powers core down between sequences.
// (R3) Periodic-run bit starts cycles over periodic channel mask.
// (R4) Clearing periodic-run finishes current cycle, clears timer, blocks more.
// (R5) One-shot trigger starts one cycle over one-shot mask, self-clears.
// (R6) Enable gates triggers; rising enable pulses core reset.
// (R7) Disabling finishes running cycle, then lowest power.
// (R8) Repeat interval in 40 us units; zero means back-to-back.
// (R9) Repeat interval only before later periodic cycles.
// (R10) Start delay before first periodic cycle; one-shot ignores delays.
// (R11) Per-channel done flag set on finish, write-1 clears.
// (R12) One-shot-done and periodic-done flags set at cycle end.
// (R13) One-shot mask bits select channels; software keeps it steady.
// (R14) Periodic mask bits select channels for every pass.
// (R15) Result registers hold 10 or 12 bits, upper bits zero.
// (R16) Software reads results with single 16 or 32-bit accesses.
// (R17) Converter clock from 8-bit high and low counts, reset 1.
// (R18) Per-channel 2-bit reference select, pad or pin.
// (R19) Read-only current reference status; unused pad drive bit.
// (R20) Switch delay on reference change, charge delay for capacitor.
// (R21) Warm-up delay in converter clocks, 10-bit, reset 202h.
// (R22) Resolution select 10 or 12 bits; justify bit shifts output.
// (R23) Channels converted in ascending order.
// (R24) Request of other mode runs right after current cycle.
// (R25) Cycle done flags clear only by writing 1.
// (R26) Result written in same cycle as channel done flag.
module sac_sequencer
    import sac_pkg::*;
#(
    parameter int NUM_CH     = 12,
    parameter int TICK_COUNT = TICK_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        conv_done_i,
    input  wire logic [11:0] conv_data_i,
    output logic             core_en_o,
    output logic             core_rst_o,
    output logic             core_pwr_o,
    output logic             conv_start_o,
    output logic      [3:0]  conv_ch_o,
    output logic             conv_clk_o,
    output logic      [1:0]  ref_sel_o,
    output logic             ref_pad_drive_o
);
    initial begin
        if (NUM_CH < 1 || NUM_CH > 12) $error("NUM_CH must be 1..12");
        if (TICK_COUNT < 1) $error("TICK_COUNT must be positive");
    end

    // Software registers
    logic [7:0]  ctrl_reg;
    logic [31:0] delay_reg;
    logic [15:0] done_flags_reg;
    logic [15:0] one_shot_mask_reg;
    logic [15:0] periodic_mask_reg;
    logic [15:0] clkcfg_reg;
    logic [23:0] refsel_reg;
    logic [29:0] refctl_reg;
    logic [16:0] core_reg;
    logic [11:0] result_reg [NUM_CH];
    // Sequencer state
    sac_state_type state_reg;
    logic        mode_periodic_reg;
    logic [15:0] active_mask_reg;
    logic [3:0]  ch_reg;
    logic        os_pend_reg;
    logic        per_pend_reg;
    logic        per_first_reg;
    logic [31:0] tick_reg;
    logic [15:0] units_reg;
    logic [15:0] wait_reg;
    logic [15:0] dly_reg;
    logic [1:0]  ref_cur_reg;
    logic        en_prev_reg;
    logic        wr_fire;
    logic        set_chan;
    logic        cyc_end;
    logic        cclk_rise;
    logic        cclk;
    logic [31:0] bmask;
    logic [11:0] shaped;

    assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && ce_i;
    assign bmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign set_chan = (state_reg == SAC_CONV) && conv_done_i;
    assign cyc_end  = set_chan && ((active_mask_reg >> ch_reg) >> 1) == 16'h0000;

    // (R22) justify and resolution shaping
    always_comb begin
        if (core_reg[CORE_JUSTIFY] && core_reg[CORE_RES_LO +: 2] == RES_10BIT) begin
            shaped = {2'b00, conv_data_i[11:2]};
        end else if (core_reg[CORE_JUSTIFY] || core_reg[CORE_RES_LO +: 2] == RES_12BIT) begin
            shaped = conv_data_i;
        end else begin
            shaped = {conv_data_i[11:2], 2'b00};
        end
    end

    // Wishbone ack, one cycle per request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    // Read data mux; unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0;
        end else if (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            wb_dat_o <= 32'h0;
            case (wb_adr_i)
                OFF_CTRL:    wb_dat_o <= {24'h0, ctrl_reg};
                OFF_DELAY:   wb_dat_o <= delay_reg;
                OFF_DONE:    wb_dat_o <= {16'h0, done_flags_reg};
                OFF_ONESHOT: wb_dat_o <= {16'h0, one_shot_mask_reg};
                OFF_PERIOD:  wb_dat_o <= {16'h0, periodic_mask_reg};
                OFF_CLKCFG:  wb_dat_o <= {16'h0, clkcfg_reg};
                OFF_REFSEL:  wb_dat_o <= {8'h0, refsel_reg};
                // (R19) live reference status
                OFF_REFCTL:  wb_dat_o <= {ref_cur_reg, refctl_reg};
                OFF_CORE:    wb_dat_o <= {15'h0, core_reg};
                default: begin
                    for (int i = 0; i < NUM_CH; i++) begin
                        // (R15) upper bits read zero
                        if (wb_adr_i == OFF_RES0 + 8'(4 * i)) wb_dat_o <= {20'h0, result_reg[i]};
                    end
                end
            endcase
        end
    end

    // Plain read/write configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            delay_reg         <= 32'h0;
            one_shot_mask_reg <= 16'h0;
            periodic_mask_reg <= 16'h0;
            clkcfg_reg        <= {CLK_CNT_RST, CLK_CNT_RST};
            refsel_reg        <= 24'h0;
            refctl_reg        <= 30'h0;
            core_reg          <= {WARM_RESET, 3'b000, 1'b0, RES_12BIT, 1'b0};
        end else if (wr_fire) begin
            case (wb_adr_i)
                OFF_DELAY:   delay_reg <= (delay_reg & ~bmask) | (wb_dat_i & bmask);
                OFF_ONESHOT: one_shot_mask_reg <= (one_shot_mask_reg & ~bmask[15:0]) | (wb_dat_i[15:0] & bmask[15:0]);
                OFF_PERIOD:  periodic_mask_reg <= (periodic_mask_reg & ~bmask[15:0]) | (wb_dat_i[15:0] & bmask[15:0]);
                // (R17) counts of zero are not stored
                OFF_CLKCFG: begin
                    if (wb_sel_i[1] && wb_dat_i[15:8] != 8'h00) clkcfg_reg[15:8] <= wb_dat_i[15:8];
                    if (wb_sel_i[0] && wb_dat_i[7:0] != 8'h00) clkcfg_reg[7:0] <= wb_dat_i[7:0];
                end
                // (R18) per-channel reference codes
                OFF_REFSEL:  refsel_reg <= (refsel_reg & ~bmask[23:0]) | (wb_dat_i[23:0] & bmask[23:0]);
                OFF_REFCTL:  refctl_reg <= (refctl_reg & ~bmask[29:0]) | (wb_dat_i[29:0] & bmask[29:0]);
                OFF_CORE:    core_reg <= ((core_reg & ~bmask[16:0]) | (wb_dat_i[16:0] & bmask[16:0])) & 17'h1FF8F;
                default: ;
            endcase
        end
    end

    // Control register; hardware set of done flags beats software clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= 8'h0;
        end else if (ce_i) begin
            if (wr_fire && wb_adr_i == OFF_CTRL && wb_sel_i[0]) begin
                ctrl_reg[4:0] <= wb_dat_i[4:0];
                // (R25) write 1 clears only
                ctrl_reg[CTL_PDONE] <= ctrl_reg[CTL_PDONE] & ~wb_dat_i[CTL_PDONE];
                ctrl_reg[CTL_ODONE] <= ctrl_reg[CTL_ODONE] & ~wb_dat_i[CTL_ODONE];
            end else if (ctrl_reg[CTL_ONESHOT]) begin
                // (R5) trigger clears itself
                ctrl_reg[CTL_ONESHOT] <= 1'b0;
            end
            // (R12) cycle completion flags
            if (cyc_end && mode_periodic_reg) ctrl_reg[CTL_PDONE] <= 1'b1;
            if (cyc_end && !mode_periodic_reg) ctrl_reg[CTL_ODONE] <= 1'b1;
        end
    end

    // (R11) channel flags, set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_flags_reg <= 16'h0;
        end else if (ce_i) begin
            if (wr_fire && wb_adr_i == OFF_DONE) done_flags_reg <= done_flags_reg & ~(wb_dat_i[15:0] & bmask[15:0]);
            if (set_chan) done_flags_reg[ch_reg] <= 1'b1;
        end
    end

    // (R26) result stored with its flag
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_res
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    result_reg[g] <= 12'h0;
                end else if (ce_i && set_chan && ch_reg == 4'(g)) begin
                    result_reg[g] <= shaped;
                end
            end
        end
    endgenerate

    // 40 us tick prescaler, runs while periodic-run is set and no periodic request is pending
    logic tick;
    assign tick = (tick_reg == 32'(TICK_COUNT - 1));
    always_ff @(posedge clk_i) begin
        if (rst_i || ctrl_reg[CTL_HWRST] || !ctrl_reg[CTL_PERIODIC] || per_pend_reg) begin
            tick_reg <= 32'h0;
        end else if (ce_i) begin
            tick_reg <= tick ? 32'h0 : tick_reg + 32'h1;
        end
    end

    // (R4) (R8) (R9) (R10) periodic scheduling
    always_ff @(posedge clk_i) begin
        if (rst_i || ctrl_reg[CTL_HWRST]) begin
            units_reg     <= 16'h0;
            per_pend_reg  <= 1'b0;
            per_first_reg <= 1'b1;
        end else if (ce_i) begin
            if (!ctrl_reg[CTL_PERIODIC] || !ctrl_reg[CTL_ENABLE]) begin
                units_reg     <= 16'h0;
                per_pend_reg  <= 1'b0;
                per_first_reg <= 1'b1;
            end else if (cyc_end && mode_periodic_reg) begin
                units_reg <= 16'h0;
            end else if (state_reg == SAC_IDLE && per_pend_reg && !os_pend_reg) begin
                per_pend_reg  <= 1'b0;
                per_first_reg <= 1'b0;
            end else if (!per_pend_reg && !(state_reg != SAC_IDLE && mode_periodic_reg)) begin
                if (units_reg >= (per_first_reg ? delay_reg[15:0] : delay_reg[31:16])) begin
                    per_pend_reg <= 1'b1;
                end else if (tick) begin
                    units_reg <= units_reg + 16'h1;
                end
            end
        end
    end

    // (R5) (R6) one-shot request latch
    always_ff @(posedge clk_i) begin
        if (rst_i || ctrl_reg[CTL_HWRST]) begin
            os_pend_reg <= 1'b0;
        end else if (ce_i) begin
            if (ctrl_reg[CTL_ONESHOT] && ctrl_reg[CTL_ENABLE]) os_pend_reg <= 1'b1;
            else if (state_reg == SAC_IDLE && os_pend_reg) os_pend_reg <= 1'b0;
        end
    end

    // Conversion sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i || ctrl_reg[CTL_HWRST]) begin
            // (R1) logic reset, registers kept
            state_reg         <= SAC_IDLE;
            mode_periodic_reg <= 1'b0;
            active_mask_reg   <= 16'h0;
            ch_reg            <= 4'h0;
            dly_reg           <= 16'h0;
            wait_reg          <= 16'h0;
            ref_cur_reg       <= 2'b00;
            conv_start_o      <= 1'b0;
        end else if (ce_i) begin
            conv_start_o <= 1'b0;
            case (state_reg)
                SAC_IDLE: begin
                    // (R24) one-shot first, then periodic
                    if (os_pend_reg || per_pend_reg) begin
                        mode_periodic_reg <= !os_pend_reg;
                        // (R13) (R14) mask per mode
                        active_mask_reg <= (os_pend_reg ? one_shot_mask_reg : periodic_mask_reg)
                                           & 16'((1 << NUM_CH) - 1);
                        wait_reg <= 16'h0;
                        state_reg <= SAC_WARM;
                    end
                end
                SAC_WARM: begin
                    // (R21) warm-up in converter clocks
                    if (active_mask_reg == 16'h0) begin
                        state_reg <= SAC_IDLE;
                    end else if (wait_reg >= 16'(core_reg[16:CORE_WARM_LO])) begin
                        ch_reg    <= 4'h0;
                        state_reg <= SAC_NEXT;
                    end else if (cclk_rise) begin
                        wait_reg <= wait_reg + 16'h1;
                    end
                end
                SAC_NEXT: begin
                    // (R23) ascending channel scan
                    if (!active_mask_reg[ch_reg]) begin
                        ch_reg <= ch_reg + 4'h1;
                    end else if (refsel_reg[2 * ch_reg +: 2] != ref_cur_reg) begin
                        ref_cur_reg <= refsel_reg[2 * ch_reg +: 2];
                        dly_reg     <= 16'h0;
                        state_reg   <= SAC_REFSW;
                    end else begin
                        conv_start_o <= 1'b1;
                        state_reg    <= SAC_CONV;
                    end
                end
                SAC_REFSW: begin
                    // (R20) switch plus charge delay
                    if (dly_reg >= 16'(refctl_reg[28:REF_SW_LO]) + refctl_reg[15:0]) begin
                        conv_start_o <= 1'b1;
                        state_reg    <= SAC_CONV;
                    end else begin
                        dly_reg <= dly_reg + 16'h1;
                    end
                end
                SAC_CONV: begin
                    if (conv_done_i) begin
                        ch_reg    <= ch_reg + 4'h1;
                        state_reg <= cyc_end ? SAC_IDLE : SAC_NEXT;
                    end
                end
                default: state_reg <= SAC_IDLE;
            endcase
        end
    end

    // (R2) (R6) (R7) core enable, power and reset pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_prev_reg     <= 1'b0;
            core_rst_o      <= 1'b0;
            core_en_o       <= 1'b0;
            core_pwr_o      <= 1'b0;
            conv_ch_o       <= 4'h0;
            ref_sel_o       <= 2'b00;
            ref_pad_drive_o <= 1'b0;
        end else if (ce_i) begin
            en_prev_reg     <= ctrl_reg[CTL_ENABLE];
            core_rst_o      <= (ctrl_reg[CTL_ENABLE] && !en_prev_reg) || ctrl_reg[CTL_HWRST];
            core_en_o       <= state_reg != SAC_IDLE;
            core_pwr_o      <= state_reg != SAC_IDLE || (ctrl_reg[CTL_ENABLE] && ctrl_reg[CTL_PSDIS]);
            conv_ch_o       <= ch_reg;
            ref_sel_o       <= ref_cur_reg;
            // (R19) unused pad drive control
            ref_pad_drive_o <= refctl_reg[REF_PADDRV];
        end
    end

    sac_clkgen u_clkgen (
        .clk_i      (clk_i),
        .rst_i      (rst_i || ctrl_reg[CTL_HWRST]),
        .ce_i       (ce_i),
        .run_i      (state_reg != SAC_IDLE),
        .high_cnt_i (clkcfg_reg[15:8]),
        .low_cnt_i  (clkcfg_reg[7:0]),
        .cclk_o     (cclk),
        .rise_o     (cclk_rise)
    );
    always_ff @(posedge clk_i) begin
        if (rst_i) conv_clk_o <= 1'b0;
        else if (ce_i) conv_clk_o <= cclk;
    end

    // Assertions
    AST_ONESHOT_SELFCLR: assert property (@(posedge clk_i) disable iff (rst_i) // (R5)
        ce_i && ctrl_reg[CTL_ONESHOT] && !wr_fire |=> !ctrl_reg[CTL_ONESHOT])
        else $error("one-shot trigger did not clear");
    AST_CHAN_FLAG: assert property (@(posedge clk_i) disable iff (rst_i || ctrl_reg[CTL_HWRST]) // (R11)
        ce_i && set_chan |=> done_flags_reg[$past(ch_reg)])
        else $error("channel flag not set");
    AST_ODONE: assert property (@(posedge clk_i) disable iff (rst_i) // (R12)
        ce_i && cyc_end && !mode_periodic_reg |=> ctrl_reg[CTL_ODONE])
        else $error("one-shot done not set");
    AST_PDONE: assert property (@(posedge clk_i) disable iff (rst_i) // (R12)
        ce_i && cyc_end && mode_periodic_reg |=> ctrl_reg[CTL_PDONE])
        else $error("periodic done not set");
    AST_DONE_STICKY: assert property (@(posedge clk_i) disable iff (rst_i) // (R25)
        ctrl_reg[CTL_ODONE] && !(wr_fire && wb_adr_i == OFF_CTRL) |=> ctrl_reg[CTL_ODONE])
        else $error("done flag cleared itself");
    AST_ENABLE_PULSE: assert property (@(posedge clk_i) disable iff (rst_i) // (R6)
        ce_i && ctrl_reg[CTL_ENABLE] && !en_prev_reg |=> core_rst_o)
        else $error("no core reset pulse");
    AST_HWRST_IDLE: assert property (@(posedge clk_i) disable iff (rst_i) // (R1)
        ctrl_reg[CTL_HWRST] |=> state_reg == SAC_IDLE)
        else $error("sequencer ran in reset");
    sequence seq_conv_end;
        ce_i && set_chan;
    endsequence
    AST_ASCEND: assert property (@(posedge clk_i) disable iff (rst_i || ctrl_reg[CTL_HWRST]) // (R23)
        seq_conv_end ##0 !cyc_end |=> ch_reg == $past(ch_reg) + 4'h1)
        else $error("channel order broken");
    AST_NO_START_IDLE: assert property (@(posedge clk_i) disable iff (rst_i) // (R6)
        !ctrl_reg[CTL_ENABLE] && !os_pend_reg && !per_pend_reg && state_reg == SAC_IDLE
        |=> state_reg == SAC_IDLE)
        else $error("cycle began while disabled");
endmodule : sac_sequencer
`default_nettype wire

// file: verification/sac_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Converter core stand-in; slow_i stretches each conversion
module sac_core_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        slow_i,
    input  wire logic        conv_start_i,
    input  wire logic [3:0]  conv_ch_i,
    output logic             conv_done_o,
    output logic      [11:0] conv_data_o
);
    logic [4:0] wait_reg;
    logic [3:0] ch_reg;
    // Data valid only with done; inverted every cycle otherwise so stale data matches only every other cycle
    always_ff @(posedge clk_i) begin
        conv_done_o <= 1'b0;
        conv_data_o <= ~conv_data_o;
        if (rst_i) begin
            wait_reg    <= 5'h00;
            conv_data_o <= 12'hFFF;
        end else if (conv_start_i) begin
            wait_reg <= slow_i ? 5'h09 : 5'h03;
            ch_reg   <= conv_ch_i;
        end else if (wait_reg == 5'h01) begin
            wait_reg    <= 5'h00;
            conv_done_o <= 1'b1;
            conv_data_o <= {ch_reg, 8'h5A};
        end else if (wait_reg != 5'h00) begin
            wait_reg <= wait_reg - 5'h01;
        end
    end
endmodule : sac_core_model
`default_nettype wire

// file: verification/sar_adc_sequencer_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
// Drives registers over Wishbone, core model answers conversions
module sar_adc_sequencer_control_bench;
    import sac_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, ack, done, slow, start;
    logic [7:0] adr;
    logic [31:0] dat, dout, q;
    logic [11:0] cdata;
    logic [3:0] ch;
    logic core_rst, core_pwr;
    logic [3:0] seen_q[$];
    int fail_count, checks;
    sac_sequencer #(.NUM_CH(12), .TICK_COUNT(4)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack), .conv_done_i(done), .conv_data_i(cdata),
        .core_en_o(), .core_rst_o(core_rst), .core_pwr_o(core_pwr), .conv_start_o(start), .conv_ch_o(ch),
        .conv_clk_o(), .ref_sel_o(), .ref_pad_drive_o());
    sac_core_model i_core (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .conv_start_i(start),
        .conv_ch_i(ch), .conv_done_o(done), .conv_data_o(cdata));
    // Clock at 25 MHz
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // Channel order as started
    always @(posedge clk_i) if (start === 1'b1) seen_q.push_back(ch);
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t value %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One classic cycle; request held until ack is sampled high at a rising edge
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 100);
        if (n >= 100) check(32'h0, 32'h1);
        q = dout;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        check(q & m, exp);
    endtask : rd_chk
    task wait_ctl(input int b);
        int n;
        n = 0;
        do begin
            wb(1'b0, OFF_CTRL, 32'h0);
            n++;
        end while (q[b] !== 1'b1 && n < 300);
        if (n >= 300) check(32'h0, 32'h1);
    endtask : wait_ctl
    task t_reset_values;
        rd_chk(OFF_CORE, 32'hFFFFFFFF, 32'h00010106);
        rd_chk(OFF_CLKCFG, 32'h0000FFFF, 32'h00000101);
        rd_chk(8'h40, 32'hFFFFFFFF, 32'h0);
    endtask : t_reset_values
    task t_one_shot;
        seen_q.delete();
        wb(1'b1, OFF_CORE, 32'h0000010E);
        wb(1'b1, OFF_ONESHOT, 32'h00000005);
        wb(1'b1, OFF_CTRL, 32'h00000001);
        wb(1'b1, OFF_CTRL, 32'h00000003);
        wait_ctl(CTL_ODONE);
        check(32'(seen_q.size()), 32'd2);
        check({28'h0, seen_q[0]}, 32'h0);
        check({28'h0, seen_q[1]}, 32'h2);
        check({31'h0, q[CTL_ONESHOT]}, 32'h0);
        rd_chk(OFF_DONE, 32'hFFFFFFFF, 32'h5);
        rd_chk(OFF_RES0, 32'hFFFFFFFF, 32'h05A);
        rd_chk(OFF_RES0 + 8'h08, 32'hFFFFFFFF, 32'h25A);
        wb(1'b1, OFF_DONE, 32'h1);
        rd_chk(OFF_DONE, 32'hFFFFFFFF, 32'h4);
        rd_chk(OFF_CTRL, 32'h80, 32'h80);
        wb(1'b1, OFF_CTRL, 32'h81);
        rd_chk(OFF_CTRL, 32'h80, 32'h0);
    endtask : t_one_shot
    task t_periodic;
        slow <= 1'b1;
        wb(1'b1, OFF_DONE, 32'hFFFF);
        wb(1'b1, OFF_CORE, 32'h0000010C);
        wb(1'b1, OFF_DELAY, 32'h00000001);
        wb(1'b1, OFF_PERIOD, 32'h00000002);
        wb(1'b1, OFF_CTRL, 32'h00000005);
        wait_ctl(CTL_PDONE);
        wb(1'b1, OFF_CTRL, 32'h00000001);
        repeat (100) @(posedge clk_i);
        rd_chk(OFF_DONE, 32'hFFFFFFFF, 32'h2);
        rd_chk(OFF_RES0 + 8'h04, 32'hFFFFFFFF, 32'h056);
        wb(1'b1, OFF_CTRL, 32'h41);
        repeat (100) @(posedge clk_i);
        rd_chk(OFF_CTRL, 32'hFF, 32'h01);
    endtask : t_periodic
    task t_disabled;
        wb(1'b1, OFF_CTRL, 32'h0);
        repeat (2) @(posedge clk_i);
        check({31'h0, core_pwr}, 32'h0);
        wb(1'b1, OFF_CTRL, 32'h9);
        repeat (2) @(posedge clk_i);
        check({31'h0, core_pwr}, 32'h1);
        wb(1'b1, OFF_CTRL, 32'h0);
        wb(1'b1, OFF_DONE, 32'hFFFF);
        wb(1'b1, OFF_CTRL, 32'h2);
        repeat (100) @(posedge clk_i);
        rd_chk(OFF_DONE, 32'hFFFFFFFF, 32'h0);
        wb(1'b1, OFF_CTRL, 32'h10);
        check({31'h0, core_rst}, 32'h1);
        wb(1'b1, OFF_CTRL, 32'h0);
    endtask : t_disabled
    task tally_and_finish;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    // Watchdog well beyond the expected run
    initial begin
        repeat (30000) @(posedge clk_i);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dat = 32'h0; slow = 1'b0;
        fail_count = 0;
        checks = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset_values();
        t_one_shot();
        t_periodic();
        t_disabled();
        tally_and_finish();
    end
endmodule : sar_adc_sequencer_control_bench
`default_nettype wire
